// >>> cam_config_regs.sv
// Configuration and status registers of the depth camera, with save and restore
// of the register map. Assumes one-cycle read and write strobes on the control
// port from same-clock logic; error inputs are asynchronous pins.
`timescale 1ns/1ps
module cam_config_regs
   import cam_regs_pkg::*;
(
   input wire logic clk_sys,                  // System clock, 250 MHz.
   input wire logic rst_n,                    // Synchronous reset, active low.
   input wire logic reg_wr,                   // Register write strobe.
   input wire logic reg_rd,                   // Register read strobe.
   input wire logic [15:0] reg_addr,          // Register address.
   input wire logic [15:0] reg_wdata,         // Register write data.
   input wire logic [47:0] otp_station_addr,  // Factory station address.
   input wire logic [15:0] boot_attempts,     // Load attempts from boot logic.
   input wire logic [15:0] exposure_live,     // Sensor's current exposure.
   input wire logic [15:0] gain_live,         // Sensor's current gain.
   input wire logic [15:0] cal_state_a,       // Missing calibration, word a.
   input wire logic [15:0] cal_state_b,       // Missing calibration, word b.
   input wire logic [15:0] lamp1_state,       // Lamp module 1 error word.
   input wire logic [15:0] lamp2_state,       // Lamp module 2 error word.
   input wire logic lamp_temp_err,            // Lamp temperature read error pin.
   input wire logic sensor_temp_err,          // Sensor module temp error pin.
   input wire logic lamp_over_temp,           // Lamp over-temperature pin.
   input wire logic lamp_unreadable,          // Lamp state unreadable pin.
   input wire logic colour_err,               // Colour stream failure pin.
   input wire logic board_temp_err,           // Board temperature error pin.
   input wire logic sensor_comm_err,          // Sensor comm or trigger error pin.
   input wire logic fw_restored,              // Boot logic restored old firmware.
   input wire logic colour_running,           // Colour sensor is operating.
   output logic [15:0] reg_rdata,             // Read data.
   output logic reg_ack,                      // Access answered, one cycle.
   output logic reg_busy,                     // Save, restore or wipe in progress.
   output logic video_mode,                   // Continuous capture mode.
   output logic manual_trigger,               // Software trigger pulse.
   output logic snapshot_trigger,             // Snapshot request pulse.
   output logic [15:0] colour_stream_config,  // Colour stream settings word.
   output logic colour_stream_en,             // Dedicated colour stream on.
   output logic [31:0] colour_dest_ip,        // Colour stream destination.
   output logic [15:0] colour_dest_port,      // Colour stream port.
   output logic aeg_enable,                   // Auto exposure and gain on.
   output logic awb_enable,                   // Auto white balance on.
   output logic [15:0] exposure_set,          // Manual exposure to the sensor.
   output logic [15:0] gain_set,              // Manual gain to the sensor.
   output logic [47:0] station_addr,          // Station address in use.
   output logic [31:0] ip_addr,               // Applied IP address.
   output logic [31:0] subnet_mask,           // Applied subnet mask.
   output logic [31:0] gateway,               // Applied default gateway.
   output logic config_ready                  // All stored settings applied.
);
   function automatic logic is_cfg(input logic [15:0] a);
      return a[15:4] == CFG_BASE[15:4];
   endfunction : is_cfg

   logic [SY_COUNT-1:0] sy1_q, sy2_q;
   seq_state_t state_q, state_d;
   logic [4:0] idx_q, idx_d;
   logic [15:0] cfg_q [CFG_COUNT];
   logic [15:0] cfg_d [CFG_COUNT];
   logic [15:0] opctl_q, opctl_d, status_q, status_d, attempt_q, attempt_d;
   logic [15:0] rdata_q, rdata_d;
   logic [31:0] ip_q, ip_d, mask_q, mask_d, gw_q, gw_d;
   logic ack_q, ack_d, trig_q, trig_d, snap_q, snap_d, ready_q, ready_d;
   logic mem_we;
   logic [STORE_AW-1:0] mem_waddr, mem_raddr;
   logic [15:0] mem_wdata, mem_rdata;
   logic idle_wr, clr;
   logic [3:0] widx;

   regmap_store #(.W(REG_W), .AW(STORE_AW)) u_store (
      .clk_sys(clk_sys),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata_q(mem_rdata)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sy1_q <= '0;
         sy2_q <= '0;
      end else begin
         sy1_q <= {colour_running, fw_restored, sensor_comm_err, board_temp_err, colour_err,
                   lamp_unreadable, lamp_over_temp, sensor_temp_err, lamp_temp_err};
         sy2_q <= sy1_q;
      end
   end

   assign idle_wr = reg_wr && (state_q == ST_IDLE);
   assign widx = reg_addr[3:0];
   assign clr = idle_wr && (reg_addr == ADDR_OPCTL) && reg_wdata[OP_CLR_BIT];

   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      cfg_d = cfg_q;
      opctl_d = opctl_q;
      attempt_d = attempt_q;
      ip_d = ip_q;
      mask_d = mask_q;
      gw_d = gw_q;
      ready_d = ready_q;
      trig_d = 1'b0;
      snap_d = 1'b0;
      ack_d = reg_wr || reg_rd;
      rdata_d = rdata_q;
      mem_we = 1'b0;
      mem_waddr = '0;
      mem_wdata = '0;
      mem_raddr = '0;

      // Clear first, then new events, so an event in the clearing cycle survives.
      status_d = clr ? '0 : (status_q & STICKY_MASK);
      status_d[ST_COLOUR_ERR] = status_d[ST_COLOUR_ERR] | sy2_q[SY_COLOUR];
      status_d[ST_LAMP_TEMP] = sy2_q[SY_LAMP_TEMP];
      status_d[ST_SENS_TEMP] = sy2_q[SY_SENS_TEMP];
      status_d[ST_CAL_MISS] = (|cal_state_a) | (|cal_state_b);
      status_d[ST_OVER_TEMP] = sy2_q[SY_OVER_TEMP];
      status_d[ST_LAMP_ERR] = sy2_q[SY_LAMP_UNRD] | (|lamp1_state) | (|lamp2_state);
      status_d[ST_BOARD_TEMP] = sy2_q[SY_BOARD];
      status_d[ST_SENS_COMM] = sy2_q[SY_COMM];

      if (reg_rd) begin
         if (is_cfg(reg_addr)) begin
            rdata_d = cfg_q[reg_addr[3:0]];
            if (sy2_q[SY_RUN] && (reg_addr[3:0] == CFG_EXP)) begin
               rdata_d = exposure_live;
            end else if (sy2_q[SY_RUN] && (reg_addr[3:0] == CFG_GAIN)) begin
               rdata_d = gain_live;
            end
         end else begin
            case (reg_addr)
               ADDR_OPCTL: rdata_d = opctl_q;
               ADDR_STATUS: rdata_d = status_q;
               ADDR_READY: rdata_d = 16'(ready_q) << READY_BIT;
               ADDR_ATTEMPT: rdata_d = attempt_q;
               ADDR_CAL_A: rdata_d = cal_state_a;
               ADDR_CAL_B: rdata_d = cal_state_b;
               ADDR_LAMP1: rdata_d = lamp1_state;
               ADDR_LAMP2: rdata_d = lamp2_state;
               default: rdata_d = 16'h0000;
            endcase
         end
      end

      case (state_q)
         ST_BOOT_CHK: begin
            mem_raddr = '0;
            state_d = ST_BOOT_EVAL;
         end
         ST_BOOT_EVAL: begin
            if (mem_rdata == MAP_MARKER) begin
               status_d[ST_FACTORY] = 1'b0;
               mem_raddr = STORE_AW'(1);
               idx_d = '0;
               state_d = ST_BOOT_LOAD;
            end else begin
               cfg_d[CFG_STN0] = otp_station_addr[15:0];
               cfg_d[CFG_STN1] = otp_station_addr[31:16];
               cfg_d[CFG_STN2] = otp_station_addr[47:32];
               state_d = ST_BOOT_DONE;
            end
         end
         ST_BOOT_LOAD: begin
            cfg_d[idx_q[3:0]] = mem_rdata;
            mem_raddr = STORE_AW'(idx_q + 5'h02);
            idx_d = idx_q + 5'h01;
            if (idx_q == 5'(CFG_COUNT - 1)) begin
               state_d = ST_BOOT_DONE;
            end
         end
         ST_BOOT_DONE: begin
            ip_d = {cfg_q[CFG_IP_HI], cfg_q[CFG_IP_LO]};
            mask_d = {cfg_q[CFG_MASK_HI], cfg_q[CFG_MASK_LO]};
            gw_d = {cfg_q[CFG_GW_HI], cfg_q[CFG_GW_LO]};
            attempt_d = boot_attempts;
            // The boot logic drops its flag on a normal reboot, so this sets once.
            status_d[ST_FW_REST] = status_d[ST_FW_REST] | sy2_q[SY_FW_REST];
            ready_d = 1'b1;
            state_d = ST_IDLE;
         end
         ST_SAVE: begin
            mem_we = 1'b1;
            if (idx_q == 5'(CFG_COUNT)) begin
               // The marker goes last, so a save cut short looks valid only if an earlier save left one.
               mem_waddr = '0;
               mem_wdata = MAP_MARKER;
               idx_d = '0;
               state_d = ST_IDLE;
            end else begin
               mem_waddr = STORE_AW'(idx_q + 5'h01);
               mem_wdata = cfg_q[idx_q[3:0]];
               idx_d = idx_q + 5'h01;
            end
         end
         ST_WIPE: begin
            mem_we = 1'b1;
            mem_waddr = '0;
            mem_wdata = 16'h0000;
            state_d = ST_IDLE;
         end
         ST_IDLE: begin
            if (idle_wr && (reg_addr == ADDR_OPCTL)) begin
               opctl_d = 16'(reg_wdata[OP_VIDEO_BIT]);
               trig_d = reg_wdata[OP_TRIG_BIT];
               snap_d = reg_wdata[OP_SNAP_BIT];
            end else if (idle_wr && (reg_addr == ADDR_CMD)) begin
               idx_d = '0;
               if (reg_wdata == CMD_SAVE) begin
                  state_d = ST_SAVE;
               end else if (reg_wdata == CMD_FACTORY) begin
                  state_d = ST_WIPE;
               end
            end else if (idle_wr && is_cfg(reg_addr)) begin
               cfg_d[widx] = reg_wdata;
               if ((widx == CFG_AUTO) && cfg_q[CFG_AUTO][AUTO_AEG_BIT]
                   && !reg_wdata[AUTO_AEG_BIT] && sy2_q[SY_RUN]) begin
                  cfg_d[CFG_EXP] = exposure_live;
                  cfg_d[CFG_GAIN] = gain_live;
               end
               if (widx == CFG_GW_HI) begin
                  ip_d = {cfg_q[CFG_IP_HI], cfg_q[CFG_IP_LO]};
                  mask_d = {cfg_q[CFG_MASK_HI], cfg_q[CFG_MASK_LO]};
                  gw_d = {reg_wdata, cfg_q[CFG_GW_LO]};
               end
            end
         end
         default: state_d = ST_BOOT_CHK;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= ST_BOOT_CHK;
         idx_q <= '0;
         for (int i = 0; i < CFG_COUNT; i++) begin
            cfg_q[i] <= (i == int'(CFG_AUTO)) ? AUTO_RESET : 16'h0000;
         end
         opctl_q <= OPCTL_RESET;
         status_q <= STATUS_RESET;
         attempt_q <= '0;
         ip_q <= '0;
         mask_q <= '0;
         gw_q <= '0;
         ready_q <= 1'b0;
         trig_q <= 1'b0;
         snap_q <= 1'b0;
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         cfg_q <= cfg_d;
         opctl_q <= opctl_d;
         status_q <= status_d;
         attempt_q <= attempt_d;
         ip_q <= ip_d;
         mask_q <= mask_d;
         gw_q <= gw_d;
         ready_q <= ready_d;
         trig_q <= trig_d;
         snap_q <= snap_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_ack = ack_q;
   assign reg_busy = (state_q != ST_IDLE);
   assign video_mode = opctl_q[OP_VIDEO_BIT];
   assign manual_trigger = trig_q;
   assign snapshot_trigger = snap_q;
   assign colour_stream_config = cfg_q[CFG_COLOUR];
   assign colour_stream_en = cfg_q[CFG_COLOUR][COLOUR_EN_BIT];
   assign colour_dest_ip = {cfg_q[CFG_DIP_HI], cfg_q[CFG_DIP_LO]};
   assign colour_dest_port = cfg_q[CFG_DPORT];
   assign aeg_enable = cfg_q[CFG_AUTO][AUTO_AEG_BIT];
   assign awb_enable = cfg_q[CFG_AUTO][AUTO_AWB_BIT];
   assign exposure_set = cfg_q[CFG_EXP];
   assign gain_set = cfg_q[CFG_GAIN];
   assign station_addr = {cfg_q[CFG_STN2], cfg_q[CFG_STN1], cfg_q[CFG_STN0]};
   assign ip_addr = ip_q;
   assign subnet_mask = mask_q;
   assign gateway = gw_q;
   assign config_ready = ready_q;

   a_stream_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
      idle_wr && (reg_addr == CFG_BASE + 16'(CFG_COLOUR))
      |=> colour_stream_en == $past(reg_wdata[COLOUR_EN_BIT]))
      else $error("colour stream enable not taken from write");
   a_dest_port: assert property (@(posedge clk_sys) disable iff (!rst_n)
      idle_wr && (reg_addr == CFG_BASE + 16'(CFG_DPORT))
      |=> colour_dest_port == $past(reg_wdata))
      else $error("destination port not applied at once");
   a_ip_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      idle_wr && (reg_addr == CFG_BASE + 16'(CFG_IP_LO)) |=> $stable(ip_addr))
      else $error("IP address applied before gateway write");
   a_ip_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
      idle_wr && (reg_addr == CFG_BASE + 16'(CFG_GW_HI))
      |=> gateway[31:16] == $past(reg_wdata)
          && ip_addr == {cfg_q[CFG_IP_HI], cfg_q[CFG_IP_LO]})
      else $error("network settings not applied on gateway write");
   a_ready_late: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(config_ready) |-> $past(state_q == ST_BOOT_DONE) && reg_busy == 1'b0)
      else $error("ready set before settings applied");
   a_status_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clr && !sy2_q[SY_COLOUR] |=> !status_q[ST_COLOUR_ERR] && !status_q[ST_FW_REST])
      else $error("status clear did not clear sticky bit");
   a_recover_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      status_q[ST_FW_REST] && !clr |=> status_q[ST_FW_REST])
      else $error("recovery flag dropped without clear");
   a_lamp_temp: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sy2_q[SY_LAMP_TEMP] ##1 !sy2_q[SY_LAMP_TEMP] |=> !status_q[ST_LAMP_TEMP])
      else $error("lamp temperature flag did not self clear");
   a_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
      idle_wr && (reg_addr == CFG_BASE + 16'(CFG_AUTO)) && aeg_enable
      && !reg_wdata[AUTO_AEG_BIT] && sy2_q[SY_RUN]
      |=> exposure_set == $past(exposure_live) && gain_set == $past(gain_live))
      else $error("exposure and gain not frozen on auto off");
   a_exposure_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && (reg_addr == CFG_BASE + 16'(CFG_EXP)) && sy2_q[SY_RUN]
      |=> reg_ack && reg_rdata == $past(exposure_live))
      else $error("exposure read did not return live value");
endmodule : cam_config_regs

// >>> cam_regs_pkg.sv
// Package of register offsets, field positions, reset values and commands of the
// camera configuration and status register block.
// Assumes a 16-bit register word as seen by the control interface.
package cam_regs_pkg;
   localparam int REG_W = 16;
   localparam int STORE_AW = 5;

   // Register addresses on the control interface.
   localparam logic [15:0] ADDR_OPCTL = 16'h0001;
   localparam logic [15:0] ADDR_STATUS = 16'h0003;
   localparam logic [15:0] ADDR_READY = 16'h0010;
   localparam logic [15:0] ADDR_CMD = 16'h0011;
   localparam logic [15:0] ADDR_ATTEMPT = 16'h0012;
   localparam logic [15:0] ADDR_CAL_A = 16'h0013;
   localparam logic [15:0] ADDR_CAL_B = 16'h0014;
   localparam logic [15:0] ADDR_LAMP1 = 16'h0015;
   localparam logic [15:0] ADDR_LAMP2 = 16'h0016;
   localparam logic [15:0] CFG_BASE = 16'h0100;

   // Saved configuration words, at CFG_BASE plus index.
   localparam int CFG_COUNT = 16;
   localparam logic [3:0] CFG_COLOUR = 4'h0;
   localparam logic [3:0] CFG_DIP_LO = 4'h1;
   localparam logic [3:0] CFG_DIP_HI = 4'h2;
   localparam logic [3:0] CFG_DPORT = 4'h3;
   localparam logic [3:0] CFG_AUTO = 4'h4;
   localparam logic [3:0] CFG_EXP = 4'h5;
   localparam logic [3:0] CFG_GAIN = 4'h6;
   localparam logic [3:0] CFG_STN0 = 4'h7;
   localparam logic [3:0] CFG_STN1 = 4'h8;
   localparam logic [3:0] CFG_STN2 = 4'h9;
   localparam logic [3:0] CFG_IP_LO = 4'hA;
   localparam logic [3:0] CFG_IP_HI = 4'hB;
   localparam logic [3:0] CFG_MASK_LO = 4'hC;
   localparam logic [3:0] CFG_MASK_HI = 4'hD;
   localparam logic [3:0] CFG_GW_LO = 4'hE;
   localparam logic [3:0] CFG_GW_HI = 4'hF;

   // Field positions.
   localparam int COLOUR_EN_BIT = 2;
   localparam int AUTO_AEG_BIT = 0;
   localparam int AUTO_AWB_BIT = 1;
   localparam int OP_VIDEO_BIT = 0;
   localparam int OP_TRIG_BIT = 4;
   localparam int OP_CLR_BIT = 6;
   localparam int OP_SNAP_BIT = 11;
   localparam int READY_BIT = 1;
   localparam int ST_LAMP_TEMP = 3;
   localparam int ST_SENS_TEMP = 4;
   localparam int ST_CAL_MISS = 5;
   localparam int ST_FACTORY = 6;
   localparam int ST_FW_REST = 8;
   localparam int ST_OVER_TEMP = 9;
   localparam int ST_LAMP_ERR = 11;
   localparam int ST_COLOUR_ERR = 13;
   localparam int ST_BOARD_TEMP = 14;
   localparam int ST_SENS_COMM = 15;

   // Reset values, masks and command codes.
   localparam logic [15:0] OPCTL_RESET = 16'h0001;
   localparam logic [15:0] STATUS_RESET = 16'h0040;
   localparam logic [15:0] AUTO_RESET = 16'h0003;
   localparam logic [15:0] STICKY_MASK = 16'h2140;
   localparam logic [15:0] CMD_SAVE = 16'h00DD;
   localparam logic [15:0] CMD_FACTORY = 16'h00FA;
   localparam logic [15:0] MAP_MARKER = 16'h5A3C;

   // Synchronised pin inputs.
   localparam int SY_LAMP_TEMP = 0;
   localparam int SY_SENS_TEMP = 1;
   localparam int SY_OVER_TEMP = 2;
   localparam int SY_LAMP_UNRD = 3;
   localparam int SY_COLOUR = 4;
   localparam int SY_BOARD = 5;
   localparam int SY_COMM = 6;
   localparam int SY_FW_REST = 7;
   localparam int SY_RUN = 8;
   localparam int SY_COUNT = 9;

   typedef enum logic [6:0] {
      ST_BOOT_CHK  = 7'b0000001,
      ST_BOOT_EVAL = 7'b0000010,
      ST_BOOT_LOAD = 7'b0000100,
      ST_BOOT_DONE = 7'b0001000,
      ST_IDLE      = 7'b0010000,
      ST_SAVE      = 7'b0100000,
      ST_WIPE      = 7'b1000000
   } seq_state_t;
endpackage : cam_regs_pkg

// >>> regmap_store.sv
// Non-volatile image of the saved register map, one word written per cycle.
// Assumes the contents survive the block's reset; read data are registered.
`timescale 1ns/1ps
module regmap_store #(
   parameter int W = 16,
   parameter int AW = 5
) (
   input wire logic clk_sys,         // System clock.
   input wire logic we,              // Write strobe.
   input wire logic [AW-1:0] waddr,  // Write address.
   input wire logic [W-1:0] wdata,   // Write data.
   input wire logic [AW-1:0] raddr,  // Read address.
   output logic [W-1:0] rdata_q      // Read data, one cycle after raddr.
);
   logic [W-1:0] mem_q [2**AW];

   // The image has no reset because it stands for flash that outlives reboots.
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
   end
endmodule : regmap_store

// >>> sensor_model.sv
// Behavioural colour sensor that feeds live exposure and gain to the block.
// Assumes the system clock; live values drift every cycle while running.
`timescale 1ns/1ps
module sensor_model (
   input wire logic clk_sys, // System clock.
   input wire logic running, // Sensor operating.
   output logic [15:0] exposure_live = 16'h0100, // Live exposure.
   output logic [15:0] gain_live = 16'h0200 // Live gain.
);
   // Drifting values expose a block that latches live data at the wrong time.
   always_ff @(posedge clk_sys) begin
      if (running) begin
         exposure_live <= exposure_live + 16'h0001;
         gain_live <= gain_live - 16'h0001;
      end
   end
endmodule : sensor_model

// >>> tb_camera_config_status_regs.sv
// Self-checking bench of the camera register block over its register port.
// Assumes the block answers every strobe one cycle later with reg_ack.
`timescale 1ns/1ps
module tb_camera_config_status_regs;
   import cam_regs_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic [47:0] otp = 48'hA1B2C3D4E5F6;
   logic [15:0] cal_a = 16'h0000;
   logic [8:0] pins = 9'h000;
   logic [15:0] exp_l, gain_l, reg_rdata, c_port;
   logic reg_ack, reg_busy, aeg, auto_white_balance, c_en;
   logic [31:0] c_ip, ip, gw, mask;
   logic [47:0] stn;
   int mismatches = 0;
   int n_checks = 0;
   always #2 clk_sys = ~clk_sys;
   sensor_model partner (.clk_sys, .running(pins[8]), .exposure_live(exp_l), .gain_live(gain_l));
   cam_config_regs dut (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .otp_station_addr(otp), .boot_attempts(16'h0001), .exposure_live(exp_l),
      .gain_live(gain_l), .cal_state_a(cal_a), .cal_state_b(16'h0000),
      .lamp1_state(16'h0000), .lamp2_state(16'h0000), .lamp_temp_err(pins[0]),
      .sensor_temp_err(pins[1]), .lamp_over_temp(pins[2]), .lamp_unreadable(pins[3]),
      .colour_err(pins[4]), .board_temp_err(pins[5]), .sensor_comm_err(pins[6]),
      .fw_restored(pins[7]), .colour_running(pins[8]), .reg_rdata, .reg_ack, .reg_busy,
      .video_mode(), .manual_trigger(), .snapshot_trigger(), .colour_stream_config(),
      .colour_stream_en(c_en), .colour_dest_ip(c_ip), .colour_dest_port(c_port),
      .aeg_enable(aeg), .awb_enable(auto_white_balance), .exposure_set(), .gain_set(), .station_addr(stn),
      .ip_addr(ip), .subnet_mask(mask), .gateway(gw), .config_ready());
   task chk(input logic [47:0] got, input logic [47:0] want);
      n_checks++;
      if (got !== want) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [15:0] a, input logic [15:0] want);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk({reg_ack, reg_rdata}, {1'b1, want});
   endtask : rd
   // Reboot; the store keeps its contents across it, like flash.
   // A save still running would be cut short by the reboot, so wait for idle first.
   task boot;
      int i;
      for (i = 0; i < 100 && reg_busy !== 1'b0; i++) begin
         @(posedge clk_sys);
         #1;
      end
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      for (i = 0; i < 100 && reg_busy !== 1'b0; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk(reg_busy, 1'b0);
   endtask : boot
   task final_report;
      if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   initial begin
      #40000;
      mismatches++;
      final_report();
   end
   initial begin
      boot();
      rd(ADDR_STATUS, STATUS_RESET);
      rd(ADDR_READY, 16'h0002);
      rd(ADDR_ATTEMPT, 16'h0001);
      chk(stn, otp);
      chk({aeg, auto_white_balance}, 2'b11);
      wr(CFG_BASE + CFG_COLOUR, 16'h0004);
      chk(c_en, 1'b1);
      wr(CFG_BASE + CFG_DIP_LO, 16'h0A0B);
      wr(CFG_BASE + CFG_DIP_HI, 16'hC0A8);
      chk(c_ip, 32'hC0A80A0B);
      wr(CFG_BASE + CFG_DPORT, 16'h1F90);
      chk(c_port, 16'h1F90);
      wr(CFG_BASE + CFG_IP_LO, 16'h0001);
      wr(CFG_BASE + CFG_IP_HI, 16'h0A00);
      wr(CFG_BASE + CFG_GW_LO, 16'hFFFE);
      wr(CFG_BASE + CFG_MASK_HI, 16'hFFFF);
      chk(ip, 32'h0);
      wr(CFG_BASE + CFG_GW_HI, 16'h0A00);
      chk({ip[15:0], gw}, 48'h00010A00FFFE);
      chk(mask, 32'hFFFF0000);
      wr(CFG_BASE + CFG_AUTO, 16'h0000);
      chk({aeg, auto_white_balance}, 2'b00);
      wr(CFG_BASE + CFG_EXP, 16'h1234);
      rd(CFG_BASE + CFG_EXP, 16'h1234);
      wr(CFG_BASE + CFG_STN0, 16'hBEEF);
      chk(stn[15:0], 16'hBEEF);
      @(posedge clk_sys);
      pins <= 9'h17F;
      cal_a <= 16'h0001;
      repeat (4) @(posedge clk_sys);
      rd(ADDR_STATUS, 16'hEA78);
      wr(CFG_BASE + CFG_AUTO, 16'h0001);
      wr(CFG_BASE + CFG_AUTO, 16'h0000);
      chk(aeg, 1'b0);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= CFG_BASE + CFG_EXP;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp_l - 16'h0001);
      pins <= 9'h000;
      cal_a <= 16'h0000;
      repeat (4) @(posedge clk_sys);
      rd(ADDR_STATUS, 16'h2040);
      wr(ADDR_OPCTL, 16'h0041);
      rd(ADDR_STATUS, 16'h0000);
      wr(ADDR_CMD, CMD_SAVE);
      boot();
      rd(CFG_BASE + CFG_COLOUR, 16'h0004);
      rd(ADDR_STATUS, 16'h0000);
      chk(stn[15:0], 16'hBEEF);
      wr(ADDR_CMD, CMD_FACTORY);
      pins <= 9'h080;
      boot();
      rd(ADDR_STATUS, 16'h0140);
      pins <= 9'h000;
      boot();
      rd(ADDR_STATUS, STATUS_RESET);
      chk(stn, otp);
      final_report();
   end
endmodule : tb_camera_config_status_regs
